/* hdl/sync_serial_shift_port.sv */
// synchronous serial shift port with apb register access
`timescale 1ns/1ps
`include "sync_serial_map.svh"
module sync_serial_shift_port #(
  parameter int PRESCALER_WIDTH = `PRESCALER_WIDTH
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // serial pins
  input wire logic i_serial_clock_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_pin_oe_n,
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  output logic o_serial_out_pin_oe_n,
  // interrupt request to the processor
  output logic o_serial_irq
);

  // bits per transfer for each operating mode
  function automatic logic [4:0] xfer_len(input logic [1:0] mode);
    case (mode)
      `MODE_8BIT: xfer_len = 5'h08;
      `MODE_12BIT: xfer_len = 5'h0C;
      `MODE_16BIT: xfer_len = 5'h10;
      default: xfer_len = 5'h08;
    endcase
  endfunction

  // prescaler tap for each division ratio select
  function automatic logic [3:0] tap_index(input logic [2:0] sel);
    case (sel)
      3'h0: tap_index = 4'hC;
      3'h1: tap_index = 4'hA;
      3'h2: tap_index = 4'h5; // divide by 64
      3'h3: tap_index = 4'h4;
      3'h4: tap_index = 4'h3;
      3'h5: tap_index = 4'h2;
      3'h6: tap_index = 4'h1;
      default: tap_index = 4'h0;
    endcase
  endfunction

  // one shift toward the lsb, new bit at the top of the active length
  function automatic logic [15:0] shift_chain(
    input logic [15:0] chain,
    input logic din,
    input logic [1:0] mode
  );
    case (mode)
      `MODE_12BIT: shift_chain = {chain[15:12], din, chain[11:1]};
      `MODE_16BIT: shift_chain = {din, chain[15:1]};
      default: shift_chain = {chain[15:8], din, chain[7:1]};
    endcase
  endfunction

  // registers
  sync_serial_pkg::serial_control_t ctrl_reg;
  sync_serial_pkg::xfer_state_t state_reg;
  sync_serial_pkg::xfer_state_t state_next;
  logic [15:0] chain_reg;
  logic [15:0] chain_next;
  logic sol_reg;
  logic ovr_reg;
  logic ovr_next;
  logic irq_flag_reg;
  logic irq_flag_next;
  logic irq_en_reg;
  logic [7:0] pfs_reg;
  logic [7:0] obc_reg;
  logic sys_phase_reg;
  logic [PRESCALER_WIDTH-1:0] presc_reg;
  logic tap_prev_reg;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic seen_fall_reg;
  logic seen_fall_next;
  logic so_bit_reg;
  logic so_bit_next;
  logic [2:0] sck_sync_reg;
  logic sck_lvl_reg;
  logic [2:0] si_sync_reg;
  logic si_lvl_reg;

  // apb decode
  wire logic apb_access = i_psel & i_penable;
  wire logic apb_done = apb_access & o_pready;
  wire logic apb_wr = apb_done & i_pwrite;
  wire logic hit_ctrl = (i_paddr == `OFS_SERIAL_CONTROL);
  wire logic hit_stat = (i_paddr == `OFS_SERIAL_CONTROL_STATUS);
  wire logic hit_upper = (i_paddr == `OFS_SHIFT_DATA_UPPER);
  wire logic hit_lower = (i_paddr == `OFS_SHIFT_DATA_LOWER);
  wire logic hit_irq = (i_paddr == `OFS_IRQ_REQUEST_REG);
  wire logic hit_ien = (i_paddr == `OFS_IRQ_ENABLE_REG);
  wire logic hit_pfs = (i_paddr == `OFS_PIN_FUNCTION_SELECT);
  wire logic hit_obc = (i_paddr == `OFS_OUTPUT_BUFFER_CONTROL);
  wire logic hit_any = hit_ctrl | hit_stat | hit_upper | hit_lower |
    hit_irq | hit_ien | hit_pfs | hit_obc;
  wire logic busy = (state_reg == sync_serial_pkg::ST_SHIFT);
  wire logic [7:0] stat_view = {1'b0, sol_reg, ovr_reg, 4'h0, busy};
  wire logic [7:0] irq_view = {3'h0, irq_flag_reg, 4'h0};
  wire logic [7:0] ien_view = {3'h0, irq_en_reg, 4'h0};
  wire logic [7:0] rd_byte =
    hit_ctrl ? ctrl_reg :
    hit_stat ? stat_view :
    hit_upper ? chain_reg[15:8] :
    hit_lower ? chain_reg[7:0] :
    hit_irq ? irq_view :
    hit_ien ? ien_view :
    hit_pfs ? pfs_reg :
    hit_obc ? obc_reg : 8'h00;

  // software requests
  wire logic start_wr = apb_wr & hit_stat & i_pwdata[`BIT_START_FLAG];
  wire logic start_ok = start_wr & ~busy;
  wire logic data_wr = apb_wr & (hit_upper | hit_lower);
  wire logic ovr_clr = apb_wr & hit_stat & ~i_pwdata[`BIT_OVERRUN];
  wire logic ovr_set = busy & (start_wr | data_wr);
  wire logic irq_clr = apb_wr & hit_irq & ~i_pwdata[`BIT_IRQ_FLAG];

  // system clock enable and prescaler taps
  wire logic sys_en = sys_phase_reg;
  wire logic tap_lvl = presc_reg[tap_index(ctrl_reg.ratio_sel)];
  wire logic int_fall = tap_prev_reg & ~tap_lvl;
  wire logic int_rise = ~tap_prev_reg & tap_lvl;

  // external clock edges once two later sync stages agree
  wire logic sck_agree = (sck_sync_reg[1] == sck_sync_reg[2]);
  wire logic ext_fall = sck_agree & sck_lvl_reg & ~sck_sync_reg[1];
  wire logic ext_rise = sck_agree & ~sck_lvl_reg & sck_sync_reg[1];
  wire logic si_agree = (si_sync_reg[1] == si_sync_reg[2]);

  // transfer clock selection
  wire logic ext_sel = ctrl_reg.ext_clock_sel;
  wire logic xfer_fall = ext_sel ? ext_fall : int_fall;
  wire logic xfer_rise = ext_sel ? ext_rise : int_rise;
  wire logic [4:0] len = xfer_len(ctrl_reg.op_mode_sel);
  wire logic shift_now = busy & seen_fall_reg & xfer_rise;
  wire logic last_bit = shift_now & (cnt_reg == len - 5'h01);
  wire logic cont_mode = (ctrl_reg.op_mode_sel == `MODE_CONT_CLOCK);

  // transfer sequencing
  always_comb
  begin
    state_next = state_reg;
    chain_next = chain_reg;
    cnt_next = cnt_reg;
    seen_fall_next = seen_fall_reg;
    so_bit_next = so_bit_reg;
    case (state_reg)
      sync_serial_pkg::ST_IDLE:
      begin
        if (apb_wr & hit_upper)
        begin
          chain_next[15:8] = i_pwdata[7:0];
        end
        if (apb_wr & hit_lower)
        begin
          chain_next[7:0] = i_pwdata[7:0];
        end
        if (start_ok)
        begin
          state_next = sync_serial_pkg::ST_SHIFT;
          cnt_next = 5'h00;
          seen_fall_next = 1'b0;
        end
      end
      sync_serial_pkg::ST_SHIFT:
      begin
        // bit leaves on the falling edge, held to the rising edge
        if (xfer_fall)
        begin
          so_bit_next = chain_reg[0];
          seen_fall_next = 1'b1;
        end
        if (shift_now)
        begin
          chain_next = shift_chain(chain_reg, si_lvl_reg,
            ctrl_reg.op_mode_sel);
          cnt_next = cnt_reg + 5'h01;
        end
        if (last_bit)
        begin
          state_next = sync_serial_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_next = sync_serial_pkg::ST_IDLE;
      end
    endcase
  end

  // flags: a hardware set wins over a software clear
  assign ovr_next = ovr_set | (ovr_reg & ~ovr_clr);
  assign irq_flag_next = last_bit | (irq_flag_reg & ~irq_clr);

  // pin drive
  wire logic int_pin_clk = ext_sel ? 1'b1 : cont_mode ? tap_lvl :
    ((busy & (seen_fall_reg | int_fall)) ? tap_lvl : 1'b1);
  wire logic so_lvl = (busy & seen_fall_reg) ? so_bit_reg : sol_reg;
  wire logic pmos_off = obc_reg[`BIT_PMOS_OFF];
  wire logic so_func = pfs_reg[`BIT_PIN_SO_FUNC];
  wire logic sck_func = pfs_reg[`BIT_PIN_SCK_FUNC];
  sync_serial_pkg::pin_drive_t sck_drive;
  sync_serial_pkg::pin_drive_t so_drive;
  assign sck_drive.level = int_pin_clk;
  assign sck_drive.oe_n = ~(sck_func & ~ext_sel);
  // open drain: only a low level is driven, a high releases the pin
  assign so_drive.level = pmos_off ? 1'b0 : so_lvl;
  assign so_drive.oe_n = ~so_func | (pmos_off & so_lvl);

  // apb slave: one wait state so read data comes from a flop
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= apb_access & ~o_pready;
      o_prdata <= {24'h00_0000, rd_byte};
      o_pslverr <= apb_access & ~o_pready & ~hit_any;
    end
  end

  // software registers
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl_reg <= `RST_SERIAL_CONTROL;
      sol_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      pfs_reg <= `RST_PORT_BYTE;
      obc_reg <= `RST_PORT_BYTE;
    end
    else
    begin
      if (apb_wr & hit_ctrl)
      begin
        ctrl_reg <= i_pwdata[7:0];
      end
      if (apb_wr & hit_stat)
      begin
        sol_reg <= i_pwdata[`BIT_EXTENSION_DATA];
      end
      if (apb_wr & hit_ien)
      begin
        irq_en_reg <= i_pwdata[`BIT_IRQ_ENABLE];
      end
      if (apb_wr & hit_pfs)
      begin
        pfs_reg <= i_pwdata[7:0];
      end
      if (apb_wr & hit_obc)
      begin
        obc_reg <= i_pwdata[7:0];
      end
    end
  end

  // flags and interrupt output
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ovr_reg <= 1'b0;
      irq_flag_reg <= 1'b0;
      o_serial_irq <= 1'b0;
    end
    else
    begin
      ovr_reg <= ovr_next;
      irq_flag_reg <= irq_flag_next;
      o_serial_irq <= irq_flag_reg & irq_en_reg;
    end
  end

  // system clock halving and free-running prescaler
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sys_phase_reg <= 1'b0;
      presc_reg <= '0;
      tap_prev_reg <= 1'b0;
    end
    else
    begin
      sys_phase_reg <= sys_phase_reg ^ `SYS_CLOCK_DIVIDE;
      if (sys_en)
      begin
        presc_reg <= presc_reg + PRESCALER_WIDTH'(1);
      end
      tap_prev_reg <= tap_lvl;
    end
  end

  // pin synchronisers, three stages each
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sck_sync_reg <= 3'h7;
      sck_lvl_reg <= 1'b1;
      si_sync_reg <= 3'h0;
      si_lvl_reg <= 1'b0;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], i_serial_clock_pin};
      si_sync_reg <= {si_sync_reg[1:0], i_serial_in_pin};
      if (sck_agree)
      begin
        sck_lvl_reg <= sck_sync_reg[1];
      end
      if (si_agree)
      begin
        si_lvl_reg <= si_sync_reg[1];
      end
    end
  end

  // transfer state
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_reg <= sync_serial_pkg::ST_IDLE;
      chain_reg <= `RST_SHIFT_DATA;
      cnt_reg <= 5'h00;
      seen_fall_reg <= 1'b0;
      so_bit_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      chain_reg <= chain_next;
      cnt_reg <= cnt_next;
      seen_fall_reg <= seen_fall_next;
      so_bit_reg <= so_bit_next;
    end
  end

  // registered pin outputs
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_serial_clock_pin <= 1'b1;
      o_serial_clock_pin_oe_n <= 1'b1;
      o_serial_out_pin <= 1'b0;
      o_serial_out_pin_oe_n <= 1'b1;
    end
    else
    begin
      o_serial_clock_pin <= sck_drive.level;
      o_serial_clock_pin_oe_n <= sck_drive.oe_n;
      o_serial_out_pin <= so_drive.level;
      o_serial_out_pin_oe_n <= so_drive.oe_n;
    end
  end

endmodule // sync_serial_shift_port

/* hdl/sync_serial_map.svh */
// register map, field positions, reset values and counts of the shift port
`ifndef SYNC_SERIAL_MAP_SVH
`define SYNC_SERIAL_MAP_SVH
`define OFS_SERIAL_CONTROL 8'h00
`define OFS_SERIAL_CONTROL_STATUS 8'h04
`define OFS_SHIFT_DATA_UPPER 8'h08
`define OFS_SHIFT_DATA_LOWER 8'h0C
`define OFS_IRQ_REQUEST_REG 8'h10
`define OFS_IRQ_ENABLE_REG 8'h14
`define OFS_PIN_FUNCTION_SELECT 8'h18
`define OFS_OUTPUT_BUFFER_CONTROL 8'h1C
`define BIT_START_FLAG 0
`define BIT_OVERRUN 5
`define BIT_EXTENSION_DATA 6
`define BIT_IRQ_FLAG 4
`define BIT_IRQ_ENABLE 4
`define BIT_PIN_SO_FUNC 2
`define BIT_PIN_SCK_FUNC 0
`define BIT_PMOS_OFF 0
`define RST_SERIAL_CONTROL 8'h00
`define RST_SHIFT_DATA 16'h0000
`define RST_PORT_BYTE 8'h00
`define PRESCALER_WIDTH 13
`define SYS_CLOCK_DIVIDE 1'b1
`define MODE_8BIT 2'h0
`define MODE_12BIT 2'h1
`define MODE_16BIT 2'h2
`define MODE_CONT_CLOCK 2'h3
`endif

/* hdl/sync_serial_pkg.sv */
// types shared by the synchronous serial shift port
package sync_serial_pkg;
  typedef struct packed {
    logic [1:0] op_mode_sel;
    logic [1:0] spare;
    logic ext_clock_sel;
    logic [2:0] ratio_sel;
  } serial_control_t;
  typedef struct packed {
    logic level;
    logic oe_n;
  } pin_drive_t;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } xfer_state_t;
endpackage

/* sim/sync_serial_monitor.sv */
// port assertions for the synchronous serial shift port
`timescale 1ns/1ps
module sync_serial_monitor #(
  parameter int PRESCALER_WIDTH = 13
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // serial pins
  input wire logic o_serial_clock_pin,
  input wire logic o_serial_out_pin,
  input wire logic o_serial_out_pin_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence apb_setup;
    i_psel && !i_penable;
  endsequence
  sequence access_wait;
    !o_pready ##1 (o_pready && i_psel && i_penable);
  endsequence
  a_ready_second_access: assert property (apb_setup |=> access_wait)
    else $error("pready not in second access cycle");
  a_ready_one_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");
  a_error_decode: assert property (o_pready |->
    o_pslverr == (i_paddr > 8'h1C || i_paddr[1:0] != 2'h0))
    else $error("pslverr does not match address decode");
  a_read_byte_wide: assert property (o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_error_read_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
    else $error("unmapped read returned data");
  a_data_stable_rise: assert property ($rose(o_serial_clock_pin) |->
    $stable(o_serial_out_pin) && $stable(o_serial_out_pin_oe_n))
    else $error("data moved at a clock rise");
  a_clock_high_hold: assert property ($rose(o_serial_clock_pin) |=> o_serial_clock_pin)
    else $error("clock high phase too short");
  a_data_launch_low: assert property ($changed(o_serial_out_pin) &&
    !o_serial_out_pin_oe_n && !o_serial_clock_pin |-> $past(o_serial_clock_pin) == 1'b0)
    else $error("data changed outside the low phase");
endmodule // sync_serial_monitor

/* sim/sync_serial_peer.sv */
// behavioural far-side serial device on the data and clock pins
`timescale 1ns/1ps
module sync_serial_peer (
  // pin side
  input wire logic i_sck,
  input wire logic i_sdo,
  output logic o_sdi,
  // bench side
  input wire logic i_clear,
  input wire logic [15:0] i_tx_word,
  output logic [15:0] o_rx_word
);
  logic [3:0] cnt = 4'h0;
  initial o_sdi = 1'b1;
  // capture on the rise, when the device holds its bit still
  always @(posedge i_sck or posedge i_clear)
    if (i_clear)
      cnt <= 4'h0;
    else
    begin
      o_rx_word[cnt] <= i_sdo;
      cnt <= cnt + 4'h1;
    end
  // launch on the fall so the bit has settled through the input filter
  always @(negedge i_sck or posedge i_clear)
    if (i_clear)
      o_sdi <= ~o_sdi;
    else
      o_sdi <= i_tx_word[cnt];
endmodule // sync_serial_peer

/* sim/tb_top.sv */
// self-checking bench for the synchronous serial shift port
`timescale 1ns/1ps
`include "sync_serial_map.svh"
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, sck_o, sck_oe_n, sdo_o, sdo_oe_n, irq, sdi, err, last;
  logic peer_clr = 1'b1;
  logic ext_clk = 1'b1;
  logic [15:0] peer_tx = 16'h0000;
  logic [15:0] peer_rx;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 17449;
  int taps [8] = '{12, 10, 5, 4, 3, 2, 1, 0};
  // bench drives the released clock pin, idle high; released data pin has a pull-up
  wire sck_w = sck_oe_n ? ext_clk : sck_o;
  wire sdo_w = sdo_oe_n ? 1'b1 : sdo_o;
  always #20 i_ref_clk = ~i_ref_clk;
  sync_serial_shift_port #(.PRESCALER_WIDTH(13)) dut (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_serial_clock_pin(sck_w),
    .o_serial_clock_pin(sck_o), .o_serial_clock_pin_oe_n(sck_oe_n), .i_serial_in_pin(sdi),
    .o_serial_out_pin(sdo_o), .o_serial_out_pin_oe_n(sdo_oe_n), .o_serial_irq(irq));
  sync_serial_peer peer (.i_sck(sck_w), .i_sdo(sdo_w), .o_sdi(sdi), .i_clear(peer_clr),
    .i_tx_word(peer_tx), .o_rx_word(peer_rx));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    @(posedge i_ref_clk);
    // no limit here: only the bench timeout ends a wait for the slave
    while (pready !== 1'b1)
    begin
      @(posedge i_ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // registered pin outputs need two edges after the write lands
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge i_ref_clk);
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask
  function automatic logic [15:0] len_mask(input logic [1:0] m);
    return (m == `MODE_12BIT) ? 16'h0FFF : (m == `MODE_16BIT) ? 16'hFFFF : 16'h00FF;
  endfunction
  task automatic wait_sck(input logic lvl, inout int t);
    int n;
    n = 0;
    while (sck_o !== lvl && n < 600)
    begin
      @(posedge i_ref_clk);
      n++;
    end
    t += n;
  endtask
  task automatic xfer(input logic [1:0] m, input logic [2:0] r, input logic [15:0] d,
                      input logic en, input logic ovr);
    sync_serial_pkg::serial_control_t ctrl;
    logic [15:0] p, got;
    int t, n;
    ctrl = '{op_mode_sel: m, spare: 2'h0, ext_clock_sel: 1'b0, ratio_sel: r};
    p = 16'($random(seed));
    apb(1'b1, `OFS_SERIAL_CONTROL, {24'h0, ctrl});
    apb(1'b1, `OFS_SHIFT_DATA_UPPER, {24'h0, d[15:8]});
    apb(1'b1, `OFS_SHIFT_DATA_LOWER, {24'h0, d[7:0]});
    apb(1'b1, `OFS_IRQ_ENABLE_REG, {27'h0, en, 4'h0});
    peer_tx <= p;
    peer_clr <= 1'b1;
    @(posedge i_ref_clk);
    peer_clr <= 1'b0;
    apb(1'b1, `OFS_SERIAL_CONTROL_STATUS, 32'h01);
    if (ovr)
      apb(1'b1, `OFS_SERIAL_CONTROL_STATUS, 32'h01);
    t = 0;
    wait_sck(1'b0, t);
    wait_sck(1'b1, t);
    t = 0;
    wait_sck(1'b0, t);
    wait_sck(1'b1, t);
    chk("bit period", t, 32'h1 << (taps[r] + 2));
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 1000)
    begin
      apb(1'b0, `OFS_SERIAL_CONTROL_STATUS, 32'h0);
      n++;
    end
    chk("start flag", rd[0], 1'b0);
    chk("overrun", rd[5], ovr);
    rchk("irq flag", `OFS_IRQ_REQUEST_REG, 32'h10);
    chk("irq line", irq, en);
    if (!en)
    begin
      wr(`OFS_IRQ_ENABLE_REG, 32'h10);
      chk("irq line enabled", irq, 1'b1);
    end
    apb(1'b0, `OFS_SHIFT_DATA_UPPER, 32'h0);
    got[15:8] = rd[7:0];
    apb(1'b0, `OFS_SHIFT_DATA_LOWER, 32'h0);
    got[7:0] = rd[7:0];
    chk("received", got & len_mask(m), p & len_mask(m));
    chk("sent", peer_rx & len_mask(m), d & len_mask(m));
    wr(`OFS_IRQ_REQUEST_REG, 32'h0);
    chk("irq line cleared", irq, 1'b0);
    apb(1'b1, `OFS_SERIAL_CONTROL_STATUS, 32'h0);
    $display("test transfer mode %0d ratio %0d done", m, r);
  endtask
  // external clock: the bench toggles the clock pin, the device only listens
  task automatic xfer_ext(input logic [7:0] d);
    logic [15:0] p;
    p = 16'($random(seed));
    apb(1'b1, `OFS_SERIAL_CONTROL, 32'h08);
    apb(1'b1, `OFS_SHIFT_DATA_LOWER, {24'h0, d});
    peer_tx <= p;
    peer_clr <= 1'b1;
    @(posedge i_ref_clk);
    peer_clr <= 1'b0;
    apb(1'b1, `OFS_SERIAL_CONTROL_STATUS, 32'h01);
    repeat (8)
    begin
      repeat (16) @(posedge i_ref_clk);
      ext_clk <= 1'b0;
      repeat (16) @(posedge i_ref_clk);
      ext_clk <= 1'b1;
    end
    repeat (16) @(posedge i_ref_clk);
    apb(1'b0, `OFS_SERIAL_CONTROL_STATUS, 32'h0);
    chk("ext start flag", rd[0], 1'b0);
    apb(1'b0, `OFS_SHIFT_DATA_LOWER, 32'h0);
    chk("ext received", rd[7:0], p[7:0]);
    chk("ext sent", peer_rx[7:0], d);
    wr(`OFS_IRQ_REQUEST_REG, 32'h0);
    $display("test external clock done");
  endtask
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  initial
  begin
    int n;
    repeat (8) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    for (int a = 0; a < 32; a += 4)
      rchk("reset value", 8'(a), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    v = $random(seed) & 32'h8F;
    apb(1'b1, `OFS_SERIAL_CONTROL, v);
    rchk("control rw", `OFS_SERIAL_CONTROL, v);
    wr(`OFS_SERIAL_CONTROL, 32'h07);
    chk("clock oe port use", sck_oe_n, 1'b1);
    wr(`OFS_PIN_FUNCTION_SELECT, 32'h05);
    chk("clock oe internal", sck_oe_n, 1'b0);
    chk("clock idle", sck_o, 1'b1);
    wr(`OFS_SERIAL_CONTROL, 32'h0F);
    chk("clock oe external", sck_oe_n, 1'b1);
    wr(`OFS_SERIAL_CONTROL_STATUS, 32'h40);
    chk("out high", sdo_w, 1'b1);
    wr(`OFS_SERIAL_CONTROL_STATUS, 32'h0);
    chk("out low", sdo_w, 1'b0);
    wr(`OFS_OUTPUT_BUFFER_CONTROL, 32'h1);
    chk("open drain low", sdo_oe_n, 1'b0);
    wr(`OFS_SERIAL_CONTROL_STATUS, 32'h40);
    chk("open drain high", sdo_oe_n, 1'b1);
    wr(`OFS_OUTPUT_BUFFER_CONTROL, 32'h0);
    wr(`OFS_SERIAL_CONTROL_STATUS, 32'h0);
    $display("test registers and pins done");
    for (int i = 0; i < 6; i++)
    begin
      v = $random(seed);
      xfer(2'(i % 3), (i == 0) ? 3'h2 : 3'(v % 3) + 3'h2, v[31:16], i != 0, i == 0);
    end
    xfer_ext(v[7:0]);
    wr(`OFS_SERIAL_CONTROL, 32'hC7);
    n = 0;
    last = sck_o;
    repeat (40)
    begin
      @(posedge i_ref_clk);
      if (sck_o !== last)
        n++;
      last = sck_o;
    end
    chk("free running clock", n >= 16, 1'b1);
    $display("test continuous clock done");
    end_of_test();
  end
endmodule // tb_top
bind sync_serial_shift_port sync_serial_monitor #(.PRESCALER_WIDTH(PRESCALER_WIDTH)) u_mon (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_serial_clock_pin(o_serial_clock_pin),
  .o_serial_out_pin(o_serial_out_pin), .o_serial_out_pin_oe_n(o_serial_out_pin_oe_n));
